// file: core/rsei_consts.svh
// Purpose: Offsets, field positions, reset values and codes of the RS
//          status and interrupt-enable block.
// Assumes: Included by the package and by every design file.
// Notes:   Definitions only.
`ifndef RSEI_CONSTS_SVH
`define RSEI_CONSTS_SVH

// Bus geometry
`define RSEI_ADDR_W      8
`define RSEI_DATA_W      32
`define RSEI_STRB_W      4
`define RSEI_IDX_MSB     7
`define RSEI_IDX_LSB     2
`define RSEI_IDX_W       6

// Register byte offsets
`define RSEI_OFF_STATUS  8'h00
`define RSEI_OFF_IRQ_EN  8'h04
`define RSEI_OFF_PENDING 8'h08

// Status flag positions
`define RSEI_NFLAGS      5
`define RSEI_FLAG_ERR    0
`define RSEI_FLAG_UNCORRECTABLE_FLAG  1
`define RSEI_FLAG_ENC    2
`define RSEI_FLAG_DEC    3
`define RSEI_FLAG_PAD    4

// Enable bit positions in ecc_irq_enable
`define RSEI_EN_ERR      0
`define RSEI_EN_UNCORRECTABLE_FLAG    1
`define RSEI_EN_CODEC    2
`define RSEI_EN_PAD      4
`define RSEI_EN_WMASK    5'h17

// Reset values
`define RSEI_FLAGS_RST   5'h00
`define RSEI_IRQ_EN_RST  5'h00
`define RSEI_ZERO_WORD   32'h0000_0000

// Response codes
`define RSEI_RESP_OKAY   2'h0
`define RSEI_RESP_SLVERR 2'h2

`endif

// file: core/rsei_pkg.sv
// Purpose: Types shared by the RS status and interrupt-enable block.
// Assumes: Constants come from rsei_consts.svh.
// Notes:   Channel states are one-hot.
`include "rsei_consts.svh"

package rsei_pkg;

   typedef logic [`RSEI_NFLAGS-1:0] rsei_flags_type;

   typedef enum logic [1:0] {
      RSEI_WR_IDLE = 2'h1,
      RSEI_WR_RESP = 2'h2
   } rsei_wr_state_type;

   typedef enum logic [1:0] {
      RSEI_RD_IDLE = 2'h1,
      RSEI_RD_RESP = 2'h2
   } rsei_rd_state_type;

endpackage

// file: core/rsei_status_flags.sv
// Purpose: Sticky status flags set by codec strobes, cleared by software.
// Assumes: Strobes are one-cycle pulses on clk.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/100ps
`include "rsei_consts.svh"

module rsei_status_flags (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Hardware events and software clears
   input  wire rsei_pkg::rsei_flags_type setVec,
   input  wire rsei_pkg::rsei_flags_type clrVec,
   // Flag state
   output rsei_pkg::rsei_flags_type     flags
);

   rsei_pkg::rsei_flags_type flags_reg;
   rsei_pkg::rsei_flags_type flags_next;

   assign flags_next = setVec | (flags_reg & ~clrVec);
   assign flags      = flags_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags_reg <= `RSEI_FLAGS_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

endmodule

// file: core/rsei_status_irq.sv
// Purpose: Status flags, interrupt enables and interrupt output of a
//          Reed-Solomon correction engine, reached over AXI4-Lite.
// Assumes: Codec strobes are one-cycle pulses on clk; one clock domain.
// Notes:   Status at 0x00 (write 1 to clear), ecc_irq_enable at 0x04,
//          masked pending view at 0x08 (read only).
// Operation
// - Padding-done flag rises once zero padding after the 512B block ends.
// - Decode-done flag rises when RS decoding finishes.
// - Encode-done flag rises when encoding and parity generation finish.
// - Uncorrectable flag becomes 1 when decoding finds uncorrectable errors.
// - Uncorrectable flag reads 0 after reset.
// - Error flag rises when decoding finds bad data in the 512B block.
// - ecc_irq_enable is a 32-bit register software can read and write.
// - Any reset clears every enable bit to 0.
// - Enable bits 31:5 and 3 ignore writes and read as zero.
// - Enable bit 4 gates the padding-done interrupt.
// - Enable bit 2 gates both encode-done and decode-done interrupts.
// - Enable bit 1 gates the uncorrectable interrupt.
// - Enable bit 0 gates the error interrupt.
// - Error flag reads 0 after reset.
`timescale 1ns/100ps
`include "rsei_consts.svh"

module rsei_status_irq (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    resetn,
   // AXI4-Lite write address
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [`RSEI_ADDR_W-1:0] awaddr,
   input  wire logic [2:0]              awprot,
   // AXI4-Lite write data
   input  wire logic                    wvalid,
   output logic                         wready,
   input  wire logic [`RSEI_DATA_W-1:0] wdata,
   input  wire logic [`RSEI_STRB_W-1:0] wstrb,
   // AXI4-Lite write response
   output logic                         bvalid,
   input  wire logic                    bready,
   output logic [1:0]                   bresp,
   // AXI4-Lite read address
   input  wire logic                    arvalid,
   output logic                         arready,
   input  wire logic [`RSEI_ADDR_W-1:0] araddr,
   input  wire logic [2:0]              arprot,
   // AXI4-Lite read data
   output logic                         rvalid,
   input  wire logic                    rready,
   output logic [`RSEI_DATA_W-1:0]      rdata,
   output logic [1:0]                   rresp,
   // Codec event strobes
   input  wire logic                    padDone,
   input  wire logic                    decodeDone,
   input  wire logic                    encodeDone,
   input  wire logic                    uncorrectable,
   input  wire logic                    errorDetected,
   // Interrupt
   output logic                         eccIrq
);

   // Write channel state
   rsei_pkg::rsei_wr_state_type   wrState_reg;
   rsei_pkg::rsei_wr_state_type   wrState_next;
   logic                          awHeld_reg;
   logic                          awHeld_next;
   logic                          wHeld_reg;
   logic                          wHeld_next;
   logic [`RSEI_ADDR_W-1:0]       awAddr_reg;
   logic [`RSEI_DATA_W-1:0]       wData_reg;
   logic [`RSEI_STRB_W-1:0]       wStrb_reg;
   logic [1:0]                    bresp_reg;
   logic                          awFire;
   logic                          wFire;
   logic                          wrGo;
   logic                          wrIdle;

   // Read channel state
   rsei_pkg::rsei_rd_state_type   rdState_reg;
   rsei_pkg::rsei_rd_state_type   rdState_next;
   logic [`RSEI_DATA_W-1:0]       rdata_reg;
   logic [1:0]                    rresp_reg;
   logic                          arFire;

   // Register decode
   logic [2:0]                    wrHit;
   logic [2:0]                    rdHit;
   logic                          wrMapped;
   logic                          rdMapped;
   logic                          lowLaneOn;
   logic                          wrEnable;
   logic                          wrStatus;
   logic [`RSEI_DATA_W-1:0]       rdMux;
   logic [`RSEI_DATA_W-1:0]       statusWord;
   logic [`RSEI_DATA_W-1:0]       enableWord;
   logic [`RSEI_DATA_W-1:0]       pendingWord;

   // Block state
   logic [`RSEI_NFLAGS-1:0]       irqEn_reg;
   logic [`RSEI_NFLAGS-1:0]       irqEn_next;
   rsei_pkg::rsei_flags_type      flags;
   rsei_pkg::rsei_flags_type      setVec;
   rsei_pkg::rsei_flags_type      clrVec;
   rsei_pkg::rsei_flags_type      pending;
   logic                          eccIrq_reg;

   // Per-flag gate from the enable layout; one enable covers two flags
   function automatic rsei_pkg::rsei_flags_type flagMask(
      input logic [`RSEI_NFLAGS-1:0] en
   );
      rsei_pkg::rsei_flags_type m;
      m                   = `RSEI_FLAGS_RST;
      m[`RSEI_FLAG_ERR]   = en[`RSEI_EN_ERR];
      m[`RSEI_FLAG_UNCORRECTABLE_FLAG] = en[`RSEI_EN_UNCORRECTABLE_FLAG];
      m[`RSEI_FLAG_ENC]   = en[`RSEI_EN_CODEC];
      m[`RSEI_FLAG_DEC]   = en[`RSEI_EN_CODEC];
      m[`RSEI_FLAG_PAD]   = en[`RSEI_EN_PAD];
      return m;
   endfunction

   // One-hot hit: bit 0 status, bit 1 enable, bit 2 pending
   function automatic logic [2:0] regHit(
      input logic [`RSEI_ADDR_W-1:0] addr
   );
      logic [`RSEI_IDX_W-1:0] idx;
      logic [`RSEI_IDX_W-1:0] idxStatus;
      logic [`RSEI_IDX_W-1:0] idxEnable;
      logic [`RSEI_IDX_W-1:0] idxPending;
      logic [`RSEI_ADDR_W-1:0] offStatus;
      logic [`RSEI_ADDR_W-1:0] offEnable;
      logic [`RSEI_ADDR_W-1:0] offPending;
      offStatus  = `RSEI_OFF_STATUS;
      offEnable  = `RSEI_OFF_IRQ_EN;
      offPending = `RSEI_OFF_PENDING;
      idx        = addr[`RSEI_IDX_MSB:`RSEI_IDX_LSB];
      idxStatus  = offStatus[`RSEI_IDX_MSB:`RSEI_IDX_LSB];
      idxEnable  = offEnable[`RSEI_IDX_MSB:`RSEI_IDX_LSB];
      idxPending = offPending[`RSEI_IDX_MSB:`RSEI_IDX_LSB];
      regHit     = {idx == idxPending, idx == idxEnable, idx == idxStatus};
   endfunction

   // Implemented bits sit at the bottom of a zero word
   function automatic logic [`RSEI_DATA_W-1:0] zeroExt(
      input logic [`RSEI_NFLAGS-1:0] v
   );
      return {{(`RSEI_DATA_W-`RSEI_NFLAGS){1'b0}}, v};
   endfunction

   // Unmapped offsets answer with a slave error
   function automatic logic [1:0] respCode(
      input logic mapped
   );
      return mapped ? `RSEI_RESP_OKAY : `RSEI_RESP_SLVERR;
   endfunction

   // ---- Write channel ----
   // Address and data are caught in either order, then applied together
   assign wrIdle  = (wrState_reg == rsei_pkg::RSEI_WR_IDLE);
   assign awready = wrIdle && !awHeld_reg;
   assign wready  = wrIdle && !wHeld_reg;
   assign awFire  = awvalid && awready;
   assign wFire   = wvalid && wready;
   assign wrGo    = wrIdle && awHeld_reg && wHeld_reg;

   assign awHeld_next = wrGo ? 1'b0 : (awHeld_reg || awFire);
   assign wHeld_next  = wrGo ? 1'b0 : (wHeld_reg || wFire);

   always_comb begin
      wrState_next = wrState_reg;
      unique case (wrState_reg)
         rsei_pkg::RSEI_WR_IDLE: begin
            if (wrGo) begin
               wrState_next = rsei_pkg::RSEI_WR_RESP;
            end
         end
         rsei_pkg::RSEI_WR_RESP: begin
            if (bready) begin
               wrState_next = rsei_pkg::RSEI_WR_IDLE;
            end
         end
         // An upset code falls back to idle rather than locking the bus
         default: begin
            wrState_next = rsei_pkg::RSEI_WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrState_reg <= rsei_pkg::RSEI_WR_IDLE;
         awHeld_reg  <= 1'b0;
         wHeld_reg   <= 1'b0;
      end else begin
         wrState_reg <= wrState_next;
         awHeld_reg  <= awHeld_next;
         wHeld_reg   <= wHeld_next;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         awAddr_reg <= `RSEI_OFF_STATUS;
      end else if (awFire) begin
         awAddr_reg <= awaddr;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wData_reg <= `RSEI_ZERO_WORD;
         wStrb_reg <= '0;
      end else if (wFire) begin
         wData_reg <= wdata;
         wStrb_reg <= wstrb;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bresp_reg <= `RSEI_RESP_OKAY;
      end else if (wrGo) begin
         bresp_reg <= respCode(wrMapped);
      end
   end

   // Response stands until bready
   assign bvalid = (wrState_reg == rsei_pkg::RSEI_WR_RESP);
   assign bresp  = bresp_reg;

   // ---- Write decode ----
   // All implemented bits sit in byte lane 0
   assign wrHit     = regHit(awAddr_reg);
   assign wrMapped  = |wrHit;
   assign lowLaneOn = wStrb_reg[0];
   assign wrEnable  = wrGo && wrHit[1] && lowLaneOn;
   assign wrStatus  = wrGo && wrHit[0] && lowLaneOn;

   // Reserved bits are never stored, so they can only read as zero
   assign irqEn_next = wrEnable
                     ? (wData_reg[`RSEI_NFLAGS-1:0] & `RSEI_EN_WMASK)
                     : irqEn_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqEn_reg <= `RSEI_IRQ_EN_RST;
      end else begin
         irqEn_reg <= irqEn_next;
      end
   end

   // ---- Status flags ----
   assign setVec[`RSEI_FLAG_PAD]   = padDone;
   assign setVec[`RSEI_FLAG_DEC]   = decodeDone;
   assign setVec[`RSEI_FLAG_ENC]   = encodeDone;
   assign setVec[`RSEI_FLAG_UNCORRECTABLE_FLAG] = uncorrectable;
   assign setVec[`RSEI_FLAG_ERR]   = errorDetected;

   // Write one to clear; a zero leaves the flag alone
   assign clrVec = wrStatus ? wData_reg[`RSEI_NFLAGS-1:0] : `RSEI_FLAGS_RST;

   rsei_status_flags u_flags (
      .clk    (clk),
      .resetn (resetn),
      .setVec (setVec),
      .clrVec (clrVec),
      .flags  (flags)
   );

   // ---- Interrupt ----
   // Registered so the pin never glitches between flag and enable updates
   assign pending = flags & flagMask(irqEn_reg);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         eccIrq_reg <= 1'b0;
      end else begin
         eccIrq_reg <= |pending;
      end
   end

   assign eccIrq = eccIrq_reg;

   // ---- Read channel ----
   assign arready = (rdState_reg == rsei_pkg::RSEI_RD_IDLE);
   assign arFire  = arvalid && arready;
   assign rdHit   = regHit(araddr);
   assign rdMapped = |rdHit;

   // Read views, upper bits always zero
   assign statusWord  = zeroExt(flags);
   assign enableWord  = zeroExt(irqEn_reg);
   assign pendingWord = zeroExt(pending);

   assign rdMux = rdHit[0] ? statusWord
                : rdHit[1] ? enableWord
                : rdHit[2] ? pendingWord
                : `RSEI_ZERO_WORD;

   always_comb begin
      rdState_next = rdState_reg;
      unique case (rdState_reg)
         rsei_pkg::RSEI_RD_IDLE: begin
            if (arFire) begin
               rdState_next = rsei_pkg::RSEI_RD_RESP;
            end
         end
         rsei_pkg::RSEI_RD_RESP: begin
            if (rready) begin
               rdState_next = rsei_pkg::RSEI_RD_IDLE;
            end
         end
         // An upset code falls back to idle rather than locking the bus
         default: begin
            rdState_next = rsei_pkg::RSEI_RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdState_reg <= rsei_pkg::RSEI_RD_IDLE;
      end else begin
         rdState_reg <= rdState_next;
      end
   end

   // Data is a snapshot taken at the address handshake
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= `RSEI_ZERO_WORD;
         rresp_reg <= `RSEI_RESP_OKAY;
      end else if (arFire) begin
         rdata_reg <= rdMux;
         rresp_reg <= respCode(rdMapped);
      end
   end

   // Data stands with rvalid until rready
   assign rvalid = (rdState_reg == rsei_pkg::RSEI_RD_RESP);
   assign rdata  = rdata_reg;
   assign rresp  = rresp_reg;

endmodule

// file: test/rsei_status_irq_asserts.sv
// Purpose: Port-level checks of the RS status and enable block.
// Assumes: One clock; shadow state follows bus writes and strobes.
// Notes:   Bound to the top module.
`timescale 1ns/100ps
module rsei_status_irq_asserts (
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Write side
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [7:0]  awaddr,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        bvalid,
   input wire logic        bready,
   // Read side
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   // Events and interrupt
   input wire logic        padDone,
   input wire logic        decodeDone,
   input wire logic        encodeDone,
   input wire logic        uncorrectable,
   input wire logic        errorDetected,
   input wire logic        eccIrq
);
   logic [7:0]  wAddr;
   logic [31:0] wData;
   logic        wLane;
   logic [4:0]  enShadow;
   logic [4:0]  flagShadow;
   logic [4:0]  pendVec;
   logic [4:0]  clr;
   logic        upd;
   // Both channels held, no response yet: the update edge
   assign upd = !awready && !wready && !bvalid;
   assign clr = (upd && wLane && wAddr[7:2] == 6'h00) ? wData[4:0] : 5'h00;
   assign pendVec = flagShadow & {enShadow[4], enShadow[2], enShadow[2], enShadow[1:0]};
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wAddr <= 8'h00;
         wData <= 32'h00000000;
         wLane <= 1'b0;
         enShadow <= 5'h00;
         flagShadow <= 5'h00;
      end else begin
         if (awvalid && awready) wAddr <= awaddr;
         if (wvalid && wready) wData <= wdata;
         if (wvalid && wready) wLane <= wstrb[0];
         if (upd && wLane && wAddr[7:2] == 6'h01) enShadow <= wData[4:0] & 5'h17;
         // Set beats clear in the same cycle
         flagShadow <= (flagShadow & ~clr)
            | {padDone, decodeDone, encodeDone, uncorrectable, errorDetected};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_irq_follows: assert property (eccIrq == $past(|pendVec))
      else $error("interrupt differs from enabled flags");
   a_rst_clean: assert property ($rose(resetn) |-> !eccIrq && !bvalid && !rvalid)
      else $error("outputs not quiet after reset");
   a_en_read: assert property (arvalid && arready && araddr[7:2] == 6'h01
      |=> rdata == {27'h0000000, $past(enShadow)}) else $error("enable readback wrong");
   a_stat_read: assert property (arvalid && arready && araddr[7:2] == 6'h00
      |=> rdata == {27'h0000000, $past(flagShadow)}) else $error("status readback wrong");
   a_pend_read: assert property (arvalid && arready && araddr[7:2] == 6'h02
      |=> rdata == {27'h0000000, $past(pendVec)}) else $error("pending readback wrong");
   a_w_answer: assert property (upd |=> bvalid)
      else $error("write response late");
   a_b_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   a_r_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read response late");
   a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read response changed");
endmodule

bind rsei_status_irq rsei_status_irq_asserts chk (.clk, .resetn, .awvalid, .awready,
   .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .arvalid, .arready,
   .araddr, .rvalid, .rready, .rdata, .padDone, .decodeDone, .encodeDone,
   .uncorrectable, .errorDetected, .eccIrq);

// file: test/rsei_status_irq_bench.sv
// Purpose: Self-checking bench of the RS status and enable block.
// Assumes: AXI4-Lite master in tasks; strobes are one-cycle pulses.
// Notes:   Protection inputs are tied.
`timescale 1ns/100ps
module rsei_status_irq_bench;
   logic        clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdVal, rdata;
   logic [4:0]  evt = 5'h00;
   logic [1:0]  rdResp, rresp, wrResp, bresp;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid, eccIrq;
   int          errors = 0, testsRun = 0;
   int          eMap [5] = '{0, 1, 2, 2, 4};

   rsei_status_irq dut (.clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .padDone(evt[4]), .decodeDone(evt[3]),
      .encodeDone(evt[2]), .uncorrectable(evt[1]), .errorDetected(evt[0]), .eccIrq(eccIrq));

   always #12.5 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, na, nw;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
         @(negedge clk);
         na = !ta && awready;
         nw = !tw && wready;
         @(posedge clk);
         if (na) awvalid <= 1'b0;
         if (nw) wvalid <= 1'b0;
         ta = ta || na;
         tw = tw || nw;
      end
      do @(negedge clk); while (!bvalid);
      wrResp = bresp;
      @(posedge clk);
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (!arready);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (!rvalid);
      rdVal = rdata;
      rdResp = rresp;
      @(posedge clk);
      rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse(input int i);
      evt[i] <= 1'b1;
      @(posedge clk);
      evt <= 5'h00;
      @(posedge clk);
   endtask

   task automatic t_start;
      rd(8'h00);
      chk("status", rdVal, 32'h00000000);
      rd(8'h04);
      chk("irqEnable", rdVal, 32'h00000000);
      chk("eccIrq", eccIrq, 32'h00000000);
   endtask

   task automatic t_enable;
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h04);
      chk("irqEnable", rdVal, 32'h00000017);
      wr(8'h04, 32'h00000008);
      rd(8'h04);
      chk("irqEnable", rdVal, 32'h00000000);
   endtask

   // Each event alone: masked, wrong enables, own enable, then cleared
   task automatic t_events;
      for (int i = 0; i < 5; i++) begin
         wr(8'h04, 32'h00000000);
         pulse(i);
         rd(8'h00);
         chk("status", rdVal, 32'h1 << i);
         chk("eccIrq", eccIrq, 32'h00000000);
         wr(8'h04, 32'h17 & ~(32'h1 << eMap[i]));
         repeat (2) @(posedge clk);
         chk("eccIrq", eccIrq, 32'h00000000);
         wr(8'h04, 32'h1 << eMap[i]);
         repeat (2) @(posedge clk);
         chk("eccIrq", eccIrq, 32'h00000001);
         rd(8'h08);
         chk("pending", rdVal, 32'h1 << i);
         wr(8'h00, 32'h1 << i);
         repeat (2) @(posedge clk);
         chk("eccIrq", eccIrq, 32'h00000000);
      end
   endtask

   task automatic t_midreset;
      wr(8'h04, 32'h00000017);
      pulse(1);
      pulse(0);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk("eccIrq", eccIrq, 32'h00000000);
      rd(8'h04);
      chk("irqEnable", rdVal, 32'h00000000);
      rd(8'h00);
      chk("status", rdVal, 32'h00000000);
   endtask

   task automatic t_unmapped;
      rd(8'h0C);
      chk("badResp", rdResp, 32'h00000002);
      chk("badData", rdVal, 32'h00000000);
      wr(8'h0C, 32'h00000017);
      chk("badWrResp", wrResp, 32'h00000002);
      wr(8'h08, 32'h00000017);
      chk("pendWrResp", wrResp, 32'h00000000);
      wstrb <= 4'h0;
      wr(8'h04, 32'h00000017);
      wstrb <= 4'hF;
      chk("laneOffResp", wrResp, 32'h00000000);
      rd(8'h04);
      chk("irqEnable", rdVal, 32'h00000000);
   endtask

   // Strobe on the clearing edge: the set wins
   task automatic t_setwins;
      pulse(0);
      fork
         wr(8'h00, 32'h00000001);
         begin
            @(posedge clk);
            evt[0] <= 1'b1;
            @(posedge clk);
            evt <= 5'h00;
         end
      join
      rd(8'h00);
      chk("status", rdVal, 32'h00000001);
      wr(8'h00, 32'h00000001);
      rd(8'h00);
      chk("status", rdVal, 32'h00000000);
   endtask

   task automatic complete_run;
      $display("errors=%0d testsRun=%0d", errors, testsRun);
      if (errors == 0 && testsRun > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_start;
      t_enable;
      t_events;
      t_midreset;
      t_unmapped;
      t_setwins;
      complete_run;
   end

   // Whole run is well under a thousand cycles
   initial begin
      #200000;
      errors++;
      complete_run;
   end
endmodule
